// ---- common/cal_timer_regs.svh ----
// Register offsets, field positions, reset values and counts of the calendar timers.
`ifndef CAL_TIMER_REGS_SVH
`define CAL_TIMER_REGS_SVH
`define CT_NUM_TIMERS 4
`define CT_REG_ON_TIME 4'h0
`define CT_REG_OFF_TIME 4'h1
`define CT_REG_MODE 4'h2
`define CT_REG_STATUS 4'h3
`define CT_CH_LSB 4
`define CT_CH_W 2
`define CT_TOD_W 17
`define CT_MODE_W 4
`define CT_SEC_PER_DAY 17'd86400
`define CT_RST_TIME 17'h00000
`define CT_RST_MODE 4'h0
`define CT_ST_VALID_BIT 1
`define CT_CLK_MHZ 250
`define CT_SEC_US 1000000
`define CT_SEC_CYCLES (`CT_SEC_US * `CT_CLK_MHZ)
`endif

// ---- common/cal_timer_pkg.sv ----
// Types shared by the calendar timer block.
package cal_timer_pkg;
   typedef enum logic [3:0] {
      mode_off = 4'h0,
      mode_daily = 4'h1,
      mode_mon = 4'h2,
      mode_tue = 4'h3,
      mode_wed = 4'h4,
      mode_thu = 4'h5,
      mode_fri = 4'h6,
      mode_sat = 4'h7,
      mode_sun = 4'h8,
      working_days_mode = 4'h9,
      mon_to_sat_mode = 4'ha,
      weekend_mode = 4'hb
   } timer_mode_t;
   // Weekday encoding: 0 is Monday, 6 is Sunday.
   typedef logic [2:0] weekday_t;
   typedef logic [16:0] tod_t;
endpackage

// ---- hdl/cal_timer.sv ----
// Four calendar weekday timers with register port, forcing and status save and restore.
`timescale 1ns/1ps
`include "cal_timer_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Four channels, each with its own on time, off time and mode.
// - On and off times are seconds of the day, hours minutes seconds.
// - Mode selector has twelve settings choosing the switching days.
// - Disabled mode does not run and holds the output at zero, apart from one cycle after a restore that sets it.
// - Daily mode switches on and off once every day.
// - Single-day modes switch only on their own weekday.
// - Working-days mode switches Monday to Friday only.
// - Monday-to-Saturday mode skips only Sundays.
// - Weekend mode switches only on Saturday and Sunday.
// - Software forces an enabled output by writing its status value.
// - A forced state holds until next force, next scheduled transition or a write of the off mode, which clears it.
// - Status is saved when auxiliary power fails and restored at startup.
// - Outputs feed logic functions, blocking logic and the output matrix.
module cal_timer
#(
   parameter int unsigned SEC_CYCLES = `CT_SEC_CYCLES
)
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire cal_timer_pkg::tod_t cal_tod,
   input wire cal_timer_pkg::weekday_t cal_weekday,
   input wire logic aux_power_fail,
   input wire logic nv_restore_valid,
   input wire logic [`CT_NUM_TIMERS-1:0] nv_restore_state,
   output logic nv_save_strobe,
   output logic [`CT_NUM_TIMERS-1:0] nv_save_state,
   output logic [`CT_NUM_TIMERS-1:0] sched_out_state
);
   import cal_timer_pkg::*;

   localparam int N = `CT_NUM_TIMERS;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers; calendar and power-fail come from other domains.
   tod_t tod_m_q, tod_q, tod_p_q;
   weekday_t wd_m_q, wd_q, wd_p_q;
   logic cal_stable;
   logic [1:0] pf_m_q, pf_q;
   logic rv_m_q, rv_q;
   logic [N-1:0] rs_m_q, rs_q;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         tod_m_q <= `CT_RST_TIME;
         tod_q <= `CT_RST_TIME;
         tod_p_q <= `CT_RST_TIME;
         wd_m_q <= 3'h0;
         wd_q <= 3'h0;
         wd_p_q <= 3'h0;
         pf_m_q <= 2'h0;
         pf_q <= 2'h0;
         rv_m_q <= 1'b0;
         rv_q <= 1'b0;
         rs_m_q <= '0;
         rs_q <= '0;
      end else if (ce) begin
         tod_m_q <= cal_tod;
         tod_q <= tod_m_q;
         tod_p_q <= tod_q;
         wd_m_q <= cal_weekday;
         wd_q <= wd_m_q;
         wd_p_q <= wd_q;
         pf_m_q <= {pf_m_q[0], aux_power_fail};
         pf_q <= {pf_q[0], pf_m_q[1]};
         rv_m_q <= nv_restore_valid;
         rv_q <= rv_m_q;
         rs_m_q <= nv_restore_state;
         rs_q <= rs_m_q;
      end
   end

   // The calendar word is synchronised bit by bit, so it is only trusted once it
   // has held still for a cycle; a word caught mid-change could fake a match.
   assign cal_stable = (tod_q == tod_p_q) && (wd_q == wd_p_q);

   ////////////////////////////////////////////////////////////////////////////
   // Once-per-second tick.
   logic [31:0] sec_cnt_q;
   logic tick;
   assign tick = (sec_cnt_q == SEC_CYCLES - 1);

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sec_cnt_q <= 32'h0;
      end else if (ce) begin
         sec_cnt_q <= tick ? 32'h0 : sec_cnt_q + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register decode.
   logic [3:0] reg_sel;
   logic [1:0] ch_sel;
   logic addr_ok;
   assign reg_sel = addr[3:0];
   assign ch_sel = addr[`CT_CH_LSB +: `CT_CH_W];
   assign addr_ok = (addr[7:6] == 2'h0) && (reg_sel <= `CT_REG_STATUS);

   tod_t on_q [N];
   tod_t off_q [N];
   timer_mode_t mode_q [N];
   logic [N-1:0] state_q;
   logic restored_q;
   logic pf_seen_q;

   // Day permission for each mode.
   function automatic logic day_ok(input timer_mode_t m, input weekday_t d);
      case (m)
         mode_daily: day_ok = 1'b1;
         mode_mon, mode_tue, mode_wed, mode_thu,
         mode_fri, mode_sat, mode_sun: day_ok = (d == 3'(m - mode_mon));
         working_days_mode: day_ok = (d <= 3'h4);
         mon_to_sat_mode: day_ok = (d <= 3'h5);
         weekend_mode: day_ok = (d == 3'h5) || (d == 3'h6);
         default: day_ok = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Channels.
   logic [N-1:0] state_d;
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         logic wsel, en, ok, hit_on, hit_off, force_wr, nxt;
         assign wsel = wr && addr_ok && (ch_sel == 2'(g));
         assign en = (mode_q[g] != mode_off);
         assign ok = day_ok(mode_q[g], wd_q) && cal_stable;
         assign hit_on = tick && en && ok && (tod_q == on_q[g]);
         assign hit_off = tick && en && ok && (tod_q == off_q[g]);
         // Writing the status of an enabled timer forces it; no force flag exists.
         assign force_wr = wsel && (reg_sel == `CT_REG_STATUS) && en;
         always_comb begin
            nxt = state_q[g];
            if (!en) begin
               nxt = 1'b0;
            end else if (hit_off) begin
               nxt = 1'b0;
            end else if (hit_on) begin
               nxt = 1'b1;
            end else if (force_wr) begin
               nxt = wdata[0];
            end
         end
         assign state_d[g] = nxt;
         always_ff @(posedge mclk) begin
            if (!rstn) begin
               on_q[g] <= `CT_RST_TIME;
               off_q[g] <= `CT_RST_TIME;
               mode_q[g] <= timer_mode_t'(`CT_RST_MODE);
            end else if (ce && wsel) begin
               if (reg_sel == `CT_REG_ON_TIME && wdata[16:0] < `CT_SEC_PER_DAY) begin
                  on_q[g] <= wdata[16:0];
               end
               if (reg_sel == `CT_REG_OFF_TIME && wdata[16:0] < `CT_SEC_PER_DAY) begin
                  off_q[g] <= wdata[16:0];
               end
               if (reg_sel == `CT_REG_MODE && wdata[3:0] <= 4'hb) begin
                  mode_q[g] <= timer_mode_t'(wdata[3:0]);
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // State, restore and save.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state_q <= '0;
         restored_q <= 1'b0;
         pf_seen_q <= 1'b0;
         nv_save_strobe <= 1'b0;
         nv_save_state <= '0;
         sched_out_state <= '0;
      end else if (ce) begin
         // Restore only once after startup so later loads cannot override the schedule.
         if (!restored_q && rv_q) begin
            state_q <= rs_q;
            restored_q <= 1'b1;
         end else begin
            state_q <= state_d;
         end
         pf_seen_q <= pf_q[1];
         nv_save_strobe <= pf_q[1] && !pf_seen_q;
         if (pf_q[1] && !pf_seen_q) begin
            nv_save_state <= state_q;
         end
         sched_out_state <= state_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port.
   logic [31:0] rd_mux;
   logic [1:0] st_val;
   assign st_val = {mode_q[ch_sel] != mode_off, state_q[ch_sel]};
   always_comb begin
      rd_mux = 32'h0;
      if (addr_ok) begin
         case (reg_sel)
            `CT_REG_ON_TIME: rd_mux = {15'h0, on_q[ch_sel]};
            `CT_REG_OFF_TIME: rd_mux = {15'h0, off_q[ch_sel]};
            `CT_REG_MODE: rd_mux = {28'h0, mode_q[ch_sel]};
            `CT_REG_STATUS: rd_mux = {30'h0, st_val};
            default: rd_mux = 32'h0;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdata <= 32'h0;
      end else if (ce) begin
         rdata <= rd ? rd_mux : 32'h0;
      end
   end
endmodule

// ---- tb/cal_timer_chk.sv ----
// Port checker for the calendar timers.
`timescale 1ns/1ps
module cal_timer_chk
#(
   parameter int unsigned SEC_CYCLES = 10
)
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic rd,
   input wire logic aux_power_fail,
   input wire logic [31:0] rdata,
   input wire logic nv_save_strobe,
   input wire logic [3:0] nv_save_state,
   input wire logic [3:0] sched_out_state
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////
   AST_RST: assert property (disable iff (1'b0) !rstn && ce |=> sched_out_state == 4'h0)
      else $error("outputs not cleared");
   AST_RD_IDLE: assert property ($past(ce) && !$past(rd) |-> rdata == 32'h0)
      else $error("read data without read");
   AST_UNMAPPED: assert property (ce && rd && addr[7:6] != 2'h0 |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   AST_RD_WIDTH: assert property (rdata[31:17] == 15'h0)
      else $error("read data too wide");
   AST_SAVE_LAT: assert property (ce && $rose(aux_power_fail) |-> ##[1:6] nv_save_strobe)
      else $error("no save after power loss");
   AST_SAVE_PULSE: assert property (nv_save_strobe |=> !nv_save_strobe)
      else $error("save strobe too long");
   AST_SAVE_CAUSE: assert property (nv_save_strobe |-> $past(aux_power_fail, 2))
      else $error("save without power loss");
   AST_SAVE_HOLD: assert property (!nv_save_strobe |-> $stable(nv_save_state))
      else $error("saved state moved");
   ////////////////////////////////////////
   CV_OUT: cover property ($rose(sched_out_state[0]));
   CV_SAVE: cover property (nv_save_strobe);
   CV_RD: cover property (rd ##1 rdata != 32'h0);
endmodule
bind cal_timer cal_timer_chk #(.SEC_CYCLES(SEC_CYCLES)) u_chk (.mclk, .rstn, .ce, .addr, .rd,
   .aux_power_fail, .rdata, .nv_save_strobe, .nv_save_state, .sched_out_state);

// ---- tb/test_calendar_weekday_timers.sv ----
// Self-checking bench for the calendar timers.
`timescale 1ns/1ps
module test_calendar_weekday_timers;
   import cal_timer_pkg::*;
   logic mclk = 0, rstn = 0, ce = 1, wr = 0, rd = 0, aux_power_fail = 0, nv_restore_valid = 0;
   logic [7:0] addr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata;
   tod_t cal_tod = 17'h0;
   weekday_t cal_weekday = 3'h0;
   logic [3:0] nv_restore_state = 4'h0, nv_save_state, sched_out_state;
   logic nv_save_strobe;
   int n_errors = 0, checks = 0;
   // Ten cycles stand for one second so that a full week of modes stays short.
   cal_timer #(.SEC_CYCLES(10)) dut (.mclk, .rstn, .ce, .addr, .wdata, .wr, .rd, .rdata,
      .cal_tod, .cal_weekday, .aux_power_fail, .nv_restore_valid, .nv_restore_state,
      .nv_save_strobe, .nv_save_state, .sched_out_state);
   initial forever #2 mclk = ~mclk;
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      if (n_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic hold(input tod_t t, input weekday_t d);
      @(posedge mclk);
      cal_tod <= t;
      cal_weekday <= d;
      wait_cyc(24);
   endtask
   function automatic logic permit(input logic [3:0] m, input logic [2:0] d);
      return m == 4'h1 || (m >= 4'h2 && m <= 4'h8 && d == m - 4'h2) || (m == 4'h9 && d < 3'h5)
         || (m == 4'ha && d < 3'h6) || (m == 4'hb && d > 3'h4);
   endfunction
   ////////////////////////////////////////
   task automatic t_regs;
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) rd_chk({2'h0, c[1:0], r[3:0]}, 32'h0);
         wr_reg({2'h0, c[1:0], 4'h0}, 32'd86399);
         wr_reg({2'h0, c[1:0], 4'h0}, 32'd86400);
         rd_chk({2'h0, c[1:0], 4'h0}, 32'd86399);
         wr_reg({2'h0, c[1:0], 4'h2}, 32'hc);
         rd_chk({2'h0, c[1:0], 4'h2}, 32'h0);
      end
      rd_chk(8'h40, 32'h0);
   endtask
   task automatic t_force;
      wr_reg(8'h03, 32'h1);
      rd_chk(8'h03, 32'h0);
      wr_reg(8'h02, 32'h1);
      wr_reg(8'h00, 32'd10);
      wr_reg(8'h01, 32'd20);
      wr_reg(8'h03, 32'h1);
      rd_chk(8'h03, 32'h3);
      hold(17'd5, 3'h0);
      chk(sched_out_state, 32'h1);
      hold(17'd20, 3'h0);
      chk(sched_out_state, 32'h0);
      // A force written while the clock enable is low must not land.
      @(posedge mclk);
      ce <= 1'b0;
      wr_reg(8'h03, 32'h1);
      ce <= 1'b1;
      rd_chk(8'h03, 32'h2);
      wr_reg(8'h02, 32'h0);
   endtask
   task automatic t_modes;
      logic [7:0] b;
      for (int m = 0; m < 12; m++) begin
         b = {2'h0, m[1:0], 4'h0};
         wr_reg(b, 32'd100);
         wr_reg(b + 8'h1, 32'd200);
         wr_reg(b + 8'h2, m);
         for (int d = 0; d < 7; d++) begin
            hold(17'd100, d[2:0]);
            chk(sched_out_state, {3'h0, permit(m[3:0], d[2:0])} << m[1:0]);
            hold(17'd200, d[2:0]);
            chk(sched_out_state, 32'h0);
         end
         wr_reg(b + 8'h2, 32'h0);
      end
   endtask
   task automatic t_power;
      cal_tod <= 17'd7;
      wr_reg(8'h12, 32'h1);
      wr_reg(8'h13, 32'h1);
      aux_power_fail <= 1'b1;
      for (int i = 0; i < 8 && nv_save_strobe !== 1'b1; i++) wait_cyc(1);
      chk(nv_save_state, 32'h2);
      @(posedge mclk);
      aux_power_fail <= 1'b0;
      rstn <= 1'b0;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      wr_reg(8'h02, 32'h1);
      wr_reg(8'h32, 32'h1);
      nv_restore_state <= 4'h9;
      nv_restore_valid <= 1'b1;
      wait_cyc(6);
      chk(sched_out_state, 32'h9);
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      t_regs();
      t_force();
      t_modes();
      t_power();
      end_sim();
   end
   initial begin
      #100000;
      n_errors++;
      end_sim();
   end
endmodule
